// >>> ebrc_seq.sv
`timescale 1ns/1ps
`default_nettype none
module ebrc_seq
    import ebrc_pkg::*;
#(
    parameter int ADDR_W = EBRC_ADDR_W,
    parameter int DATA_W = EBRC_DATA_W,
    parameter int NUM_CS = EBRC_NUM_CS
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // bus clock, sampled as a pin
    input wire logic bus_clk,
    // request side, same clock
    input wire logic req_valid,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic req_long,
    input wire logic [NUM_CS-1:0] req_region,
    input wire logic [NUM_CS-1:0] auto_ack_en,
    input wire logic [NUM_CS*4-1:0] wait_count_field,
    output logic req_ready,
    output logic rsp_valid,
    output logic [2*DATA_W-1:0] rsp_data,
    output logic write_allowed,
    // bus pins
    output logic [ADDR_W-1:0] addr_out,
    output logic addr_oe,
    output logic read_write_n,
    output logic read_write_oe,
    output logic [NUM_CS-1:0] region_select_n,
    output logic output_enable_n,
    input wire logic transfer_ack_n_in,
    output logic transfer_ack_n_out,
    output logic transfer_ack_oe,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe
);
    // ****************************************************
    // elaboration checks
    // ****************************************************
    if (DATA_W != 16) begin : g_bad_w
        $error("data port must be 16 bits");
    end
    if (NUM_CS < 1) begin : g_bad_cs
        $error("need at least one region");
    end

    // ****************************************************
    // synchronised pins
    // ****************************************************
    logic bclk_lvl;      // bus clock level
    logic bclk_rise;     // rising edge seen
    logic bclk_fall;     // falling edge seen
    logic ack_lvl_n;     // synchronised external acknowledge
    logic [DATA_W-1:0] d_meta_ff;  // data first stage
    logic [DATA_W-1:0] d_sync_ff;  // data second stage

    ebrc_edge u_bclk (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pin_in(bus_clk),
        .level(bclk_lvl),
        .rise(bclk_rise),
        .fall(bclk_fall)
    );

    ebrc_edge u_ack (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pin_in(transfer_ack_n_in),
        .level(ack_lvl_n),
        .rise(),
        .fall()
    );

    // data lanes pass two flops; both paths share the same delay as bus clock
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            d_meta_ff <= '0;
            d_sync_ff <= '0;
        end
        else if (clk_en)
        begin
            d_meta_ff <= data_in;
            d_sync_ff <= d_meta_ff;
        end
    end

    // ****************************************************
    // sequencer state
    // ****************************************************
    ebrc_state_t state_ff, nxt_state;
    logic [ADDR_W-1:0] addr_ff;        // held address
    logic [NUM_CS-1:0] region_ff;      // held region
    logic long_ff;                     // longword, two word reads
    logic second_ff;                   // lower word in progress
    logic [3:0] wait_ff;               // remaining wait cycles
    logic [DATA_W-1:0] upper_ff;       // upper word store
    logic [1:0] turn_ff;               // post-read turnaround counter
    logic active_ff;                   // address and rw driven
    logic strobe_ff;                   // select and oe asserted
    logic auto_ff;                     // internal acknowledge asserted
    logic [ADDR_W-1:0] addr_out_ff;
    logic sel_auto_ff;   // drive internal acknowledge pin only for auto regions
    logic rsp_valid_ff;
    logic [2*DATA_W-1:0] rsp_data_ff;

    // per-region wait count and auto flag, one-hot region pick
    function automatic logic [3:0] pick_wait(input logic [NUM_CS-1:0] reg_sel,
                                             input logic [NUM_CS*4-1:0] fld);
        logic [3:0] w;
        w = EBRC_WAIT_RST;
        for (int i = 0; i < NUM_CS; i++)
            if (reg_sel[i])
                w = fld[i*4 +: 4];
        return w;
    endfunction

    wire sel_auto = |(region_ff & auto_ack_en);
    wire [3:0] sel_wait = pick_wait(region_ff, wait_count_field);
    // acknowledge seen: internal when auto, else external pin
    wire ack_seen = sel_auto ? (wait_ff == 4'h0) : ~ack_lvl_n;
    wire start = req_valid && (state_ff == EBRC_S_IDLE || state_ff == EBRC_S_5);
    wire word1 = long_ff && !second_ff;   // more words to fetch

    // next state on bus clock edges only
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            EBRC_S_IDLE: if (bclk_rise && req_valid) nxt_state = EBRC_S_0;
            EBRC_S_0: if (bclk_fall) nxt_state = EBRC_S_1;
            EBRC_S_1: if (bclk_rise) nxt_state = EBRC_S_2;
            EBRC_S_2: if (bclk_rise && ack_seen) nxt_state = EBRC_S_4;
            EBRC_S_4: if (bclk_fall) nxt_state = EBRC_S_5;
            EBRC_S_5:
                if (bclk_rise)
                    nxt_state = (word1 || req_valid) ? EBRC_S_0 : EBRC_S_IDLE;
            default: nxt_state = EBRC_S_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            state_ff <= EBRC_S_IDLE;
        else if (clk_en)
            state_ff <= nxt_state;
    end

    // request capture and word sequencing
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            addr_ff <= '0;
            region_ff <= '0;
            long_ff <= 1'b0;
            second_ff <= 1'b0;
        end
        else if (clk_en && bclk_rise)
        begin
            if (state_ff == EBRC_S_5 && word1)
            begin
                second_ff <= 1'b1;                  // lower word next
                addr_ff <= addr_ff + ADDR_W'(1);    // next 16-bit word
            end
            else if (start)
            begin
                addr_ff <= req_addr;
                region_ff <= req_region;
                long_ff <= req_long;
                second_ff <= 1'b0;
            end
        end
    end

    // wait counter: loaded in state one, counts whole bus clocks
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            wait_ff <= EBRC_WAIT_RST;
        else if (clk_en && bclk_rise)
        begin
            if (state_ff == EBRC_S_1)
                wait_ff <= sel_wait;
            else if (state_ff == EBRC_S_2 && wait_ff != 4'h0)
                wait_ff <= wait_ff - 4'h1;
        end
    end

    // ****************************************************
    // pin drive
    // ****************************************************
    // address, rw on rising edges; strobes on falling edges
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            active_ff <= 1'b0;
            strobe_ff <= 1'b0;
            addr_out_ff <= '0;
        end
        else if (clk_en)
        begin
            if (nxt_state == EBRC_S_0 && bclk_rise)
            begin
                active_ff <= 1'b1;
                addr_out_ff <= (state_ff == EBRC_S_5 && word1) ? addr_ff + ADDR_W'(1)
                             : (state_ff == EBRC_S_5 || state_ff == EBRC_S_IDLE)
                               && !word1 ? req_addr : addr_ff;
            end
            else if (state_ff == EBRC_S_5 && bclk_rise)
                active_ff <= 1'b0;                    // release
            if (nxt_state == EBRC_S_1)
                strobe_ff <= 1'b1;
            else if (nxt_state == EBRC_S_5)
                strobe_ff <= 1'b0;
        end
    end

    // internal acknowledge: asserted once the wait count is zero in state two, a bus clock before the capturing edge, negated in state four
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            auto_ff <= 1'b0;
        else if (clk_en)
        begin
            if (state_ff == EBRC_S_2 && sel_auto && wait_ff == 4'h0)
                auto_ff <= 1'b1;
            else if (state_ff == EBRC_S_4 || state_ff == EBRC_S_IDLE)
                auto_ff <= 1'b0;
        end
    end

    // data capture; longword assembles upper word first
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            upper_ff <= '0;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= '0;
        end
        else if (clk_en)
        begin
            rsp_valid_ff <= 1'b0;
            if (state_ff == EBRC_S_2 && bclk_rise && ack_seen)
            begin
                if (word1)
                    upper_ff <= d_sync_ff;
                else
                begin
                    rsp_valid_ff <= 1'b1;
                    rsp_data_ff <= long_ff ? {upper_ff, d_sync_ff} : {16'h0000, d_sync_ff};
                end
            end
        end
    end

    // turnaround: hold off write drive two bus clocks after a read
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            turn_ff <= 2'h0;
        else if (clk_en)
        begin
            if (state_ff == EBRC_S_5 && bclk_rise)
                turn_ff <= EBRC_TURN_CNT;
            else if (bclk_rise && turn_ff != 2'h0)
                turn_ff <= turn_ff - 2'h1;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    logic req_ready_ff;
    logic write_ok_ff;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            req_ready_ff <= 1'b0;
            write_ok_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            req_ready_ff <= bclk_rise && start && !word1;
            write_ok_ff <= (turn_ff == 2'h0) && (state_ff == EBRC_S_IDLE);
        end
    end

    // region selects held as a flop vector
    logic [NUM_CS-1:0] cs_n_ff;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            cs_n_ff <= '1;
        else if (clk_en)
            cs_n_ff <= (nxt_state == EBRC_S_1 || (strobe_ff && nxt_state != EBRC_S_5))
                       ? ~region_ff : '1;
    end

    assign req_ready = req_ready_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rsp_data_ff;
    assign write_allowed = write_ok_ff;
    assign addr_out = addr_out_ff;
    assign addr_oe = active_ff;
    assign read_write_n = 1'b1;            // reads only
    assign read_write_oe = active_ff;
    assign region_select_n = cs_n_ff;
    assign output_enable_n = ~strobe_ff;
    assign transfer_ack_n_out = ~auto_ff;
    assign transfer_ack_oe = sel_auto_ff;
    assign data_out = '0;
    assign data_oe = 1'b0;                 // never drive data on reads

    // acknowledge drive enable, one cycle behind the internal acknowledge
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            sel_auto_ff <= 1'b0;
        else if (clk_en)
            sel_auto_ff <= auto_ff;
    end

    logic unused_lvl;    // bus clock level only used for edges
    assign unused_lvl = bclk_lvl;
endmodule // ebrc_seq
`default_nettype wire

// >>> ebrc_pkg.sv
package ebrc_pkg;
    // ****************************************************
    // bus geometry
    // ****************************************************
    localparam int EBRC_ADDR_W = 23;     // address lines
    localparam int EBRC_DATA_W = 16;     // 16-bit data port
    localparam int EBRC_NUM_CS = 2;      // region selects
    localparam int EBRC_WAIT_W = 4;      // width of one region's wait count in wait_count_field
    // ****************************************************
    // reset values and counts
    // ****************************************************
    localparam logic [3:0] EBRC_WAIT_RST = 4'h0;       // no wait states after reset
    localparam int EBRC_TURN_BCLK = 2;                 // bus clocks with no write drive
    localparam logic [1:0] EBRC_TURN_CNT = 2'h2;       // same, at counter width
    localparam int EBRC_SYNC_STAGES = 2;               // synchroniser depth
    // ****************************************************
    // sequencer states
    // ****************************************************
    typedef enum logic [2:0] {
        EBRC_S_IDLE = 3'b111,
        EBRC_S_0 = 3'b000,   // address and read_write_n out
        EBRC_S_1 = 3'b001,   // region select and output enable asserted
        EBRC_S_2 = 3'b010,   // waiting for acknowledge
        EBRC_S_4 = 3'b100,   // acknowledge being negated
        EBRC_S_5 = 3'b101    // strobes negated, then release
    } ebrc_state_t;
endpackage : ebrc_pkg

// >>> ebrc_edge.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// synchroniser and edge finder for one pin
// ****************************************************
module ebrc_edge
    import ebrc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic pin_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_ff;   // first stage, read only by sync_ff
    logic sync_ff;   // second stage
    logic last_ff;   // delayed copy for edge finding

    // two-stage synchroniser, then one more stage for edges
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise = sync_ff & ~last_ff;
    assign fall = ~sync_ff & last_ff;
endmodule // ebrc_edge
`default_nettype wire

// >>> ebrc_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// read cycle checker
// ********
module ebrc_seq_chk
    import ebrc_pkg::*;
#(
    parameter int ADDR_W = EBRC_ADDR_W,
    parameter int NUM_CS = EBRC_NUM_CS
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic write_allowed,
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic addr_oe,
    input wire logic read_write_n,
    input wire logic read_write_oe,
    input wire logic [NUM_CS-1:0] region_select_n,
    input wire logic output_enable_n,
    input wire logic data_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire sel_any = ~&region_select_n; // some region strobed
    // strobe phase lasts far beyond eight system clocks
    sequence s_strobe_on;
        $fell(output_enable_n);
    endsequence
    sequence s_held;
        !output_enable_n [*8];
    endsequence
    a_no_data_drive: assert property (!data_oe)
        else $error("data bus driven during read");
    a_rw_read_high: assert property (addr_oe |-> read_write_n && read_write_oe)
        else $error("read_write_n not high with address");
    a_rw_oe_follow: assert property (read_write_oe == addr_oe)
        else $error("read_write_n drive differs from address drive");
    a_strobe_pairs: assert property (sel_any == !output_enable_n)
        else $error("select and output enable apart");
    a_one_region: assert property ($onehot0(~region_select_n))
        else $error("more than one region selected");
    a_strobe_in_addr: assert property (!output_enable_n |-> addr_oe)
        else $error("strobe without address");
    a_strobe_held: assert property (s_strobe_on |=> s_held)
        else $error("strobe too short");
    a_addr_stable: assert property (addr_oe && $past(addr_oe) && !output_enable_n
        |-> $stable(addr_out))
        else $error("address moved under strobe");
    a_rsp_in_strobe: assert property (rsp_valid |-> !output_enable_n)
        else $error("data taken outside strobe");
    a_turn_around: assert property (rsp_valid |=> !write_allowed [*8])
        else $error("write allowed right after read");
    a_ready_pulse: assert property (req_ready |=> !req_ready)
        else $error("accept not a pulse");
endmodule // ebrc_seq_chk
`default_nettype wire

// >>> ebrc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// external memory on a region select
// ********
module ebrc_mem_model
    import ebrc_pkg::*;
(
    input wire logic bus_clk,
    input wire logic [EBRC_ADDR_W-1:0] addr_out,
    input wire logic [EBRC_NUM_CS-1:0] region_select_n,
    input wire logic output_enable_n,
    input wire logic [3:0] ext_wait,
    output logic ack_n,
    output logic [EBRC_DATA_W-1:0] data
);
    logic [3:0] cnt; // falls seen while selected
    logic done; // answered in this cycle
    initial
    begin
        ack_n = 1'b1;
        data = 16'h0000;
        cnt = 4'h0;
        done = 1'b0;
    end
    // falling edges only, so data and ack hold across the sampling rise
    always @(negedge bus_clk)
    begin
        if (&region_select_n || output_enable_n)
        begin
            ack_n <= 1'b1; // pull-up level
            data <= ~data; // released bus keeps moving
            cnt <= 4'h0;
            done <= 1'b0;
        end
        else if (!ack_n)
        begin
            ack_n <= 1'b1;
            data <= ~data;
            done <= 1'b1;
        end
        else if (!done)
        begin
            // data stands from the first selected fall, so auto-acknowledge finds it
            data <= addr_out[15:0] ^ 16'h5a5a;
            if (cnt == ext_wait)
                ack_n <= 1'b0;
            else
                cnt <= cnt + 4'h1; // stall
        end
        // released data moves on every fall, and
    end
endmodule // ebrc_mem_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ebrc_pkg::*;
;
    // ********
    // stimulus and wires
    // ********
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic bus_clk = 1'b0;
    logic req_valid = 1'b0;
    logic req_long = 1'b0;
    logic [EBRC_ADDR_W-1:0] req_addr = '0;
    logic [1:0] req_region = 2'h1;
    logic [1:0] auto_ack_en = 2'h0;
    logic [7:0] wcf = 8'h00;
    logic [3:0] ext_wait = 4'h0;
    logic req_ready, rsp_valid, write_allowed, addr_oe, read_write_n, read_write_oe;
    logic output_enable_n, ack_out, ack_oe, data_oe, model_ack, oe_q;
    logic [31:0] rsp_data;
    logic [EBRC_ADDR_W-1:0] addr_out;
    logic [1:0] region_select_n;
    logic [15:0] data_out, model_data;
    int drops = 0; // address drive gaps
    int err_total = 0;
    int n_compared = 0;
    // ack is open drain with pull-up
    wire ack_wire = model_ack & (ack_oe ? ack_out : 1'b1);
    wire [15:0] data_wire = data_oe ? data_out : model_data;
    always #2 sys_clk = ~sys_clk;
    // bus clock off phase from the system clock
    initial
    begin
        #1.3;
        forever #40 bus_clk = ~bus_clk;
    end
    ebrc_seq dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .bus_clk(bus_clk), .req_valid(req_valid), .req_addr(req_addr),
        .req_long(req_long), .req_region(req_region), .auto_ack_en(auto_ack_en),
        .wait_count_field(wcf), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .write_allowed(write_allowed), .addr_out(addr_out),
        .addr_oe(addr_oe), .read_write_n(read_write_n), .read_write_oe(read_write_oe),
        .region_select_n(region_select_n), .output_enable_n(output_enable_n),
        .transfer_ack_n_in(ack_wire), .transfer_ack_n_out(ack_out),
        .transfer_ack_oe(ack_oe), .data_in(data_wire), .data_out(data_out),
        .data_oe(data_oe));
    ebrc_mem_model mem_u (.bus_clk(bus_clk), .addr_out(addr_out),
        .region_select_n(region_select_n), .output_enable_n(output_enable_n),
        .ext_wait(ext_wait), .ack_n(model_ack), .data(model_data));
    // count falls of the address drive
    always @(posedge sys_clk)
    begin
        oe_q <= addr_oe;
        if (oe_q === 1'b1 && addr_oe === 1'b0)
            drops <= drops + 1;
    end
    // ********
    // shared tasks
    // ********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] pat(input logic [EBRC_ADDR_W-1:0] a);
        return a[15:0] ^ 16'h5a5a;
    endfunction
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // hold request until accepted
    task automatic issue(input logic [EBRC_ADDR_W-1:0] a, input logic lng);
        int k;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_addr <= a;
        req_long <= lng;
        k = 0;
        do @(posedge sys_clk); while (req_ready !== 1'b1 && ++k < 300);
        req_valid <= 1'b0;
        check({31'h0, req_ready}, 32'h0000_0001);
    endtask
    // wait for answer, counting bus clock rises on the way
    task automatic await_rsp(output int rises);
        int k;
        logic bc;
        rises = 0;
        k = 0;
        bc = bus_clk;
        while (rsp_valid !== 1'b1 && k < 3000)
        begin
            @(posedge sys_clk);
            if (bus_clk && !bc)
                rises++;
            bc = bus_clk;
            k++;
        end
    endtask
    task automatic wait_rises(input int n);
        repeat (n) @(posedge bus_clk);
        repeat (6) @(posedge sys_clk);
    endtask
    // ********
    // scenarios
    // ********
    task automatic scn_reset();
        check({addr_oe, output_enable_n, region_select_n, rsp_valid, data_oe},
            32'h0000_001c);
    endtask
    task automatic scn_read(input int r, input logic auto, input logic [3:0] n,
        input logic [EBRC_ADDR_W-1:0] a);
        int rises;
        logic [1:0] oh;
        oh = 2'h1 << r;
        @(posedge sys_clk);
        req_region <= oh;
        auto_ack_en <= auto ? oh : 2'h0;
        wcf <= !auto ? 8'h00 : (r == 1 ? {n, 4'h0} : {4'h0, n});
        ext_wait <= auto ? 4'hf : n;
        issue(a, 1'b0);
        await_rsp(rises);
        check(32'(rises), 32'(n) + 32'h0000_0002);
        check(rsp_data, {16'h0000, pat(a)});
        check({30'h0, region_select_n}, {30'h0, ~oh});
    endtask
    task automatic scn_long();
        int rises;
        issue(23'h00_4440, 1'b1);
        await_rsp(rises);
        check(rsp_data, {pat(23'h00_4440), pat(23'h00_4441)});
    endtask
    task automatic scn_back();
        int rises;
        int d0;
        issue(23'h00_0100, 1'b0);
        await_rsp(rises);
        d0 = drops;
        issue(23'h00_0200, 1'b0);
        check(32'(drops - d0), 32'h0000_0000);
        await_rsp(rises);
        check(rsp_data, {16'h0000, pat(23'h00_0200)});
    endtask
    task automatic scn_turn();
        int rises;
        int k;
        issue(23'h00_0300, 1'b0);
        await_rsp(rises);
        check({31'h0, write_allowed}, 32'h0000_0000);
        k = 0;
        while (addr_oe !== 1'b0 && k < 300)
        begin
            @(posedge sys_clk);
            k++;
        end
        wait_rises(1);
        check({31'h0, write_allowed}, 32'h0000_0000);
        wait_rises(2);
        check({31'h0, write_allowed}, 32'h0000_0001);
    endtask
    // ********
    // main sequence and watchdog
    // ********
    initial
    begin
        repeat (2) @(posedge sys_clk);
        scn_reset();
        sys_rst <= 1'b0;
        scn_read(0, 1'b0, 4'h0, 23'h00_1234);
        scn_read(0, 1'b0, 4'h3, 23'h10_0a0f);
        scn_read(1, 1'b1, 4'h0, 23'h02_7777);
        scn_read(1, 1'b1, 4'h2, 23'h7f_fffe);
        scn_read(0, 1'b1, 4'h5, 23'h00_0042);
        scn_long();
        scn_back();
        scn_turn();
        give_verdict();
    end
    initial
    begin
        #100000;
        err_total++;
        give_verdict();
    end
endmodule // testbench
bind ebrc_seq ebrc_seq_chk #(.ADDR_W(ADDR_W), .NUM_CS(NUM_CS)) chk_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .write_allowed(write_allowed), .addr_out(addr_out),
    .addr_oe(addr_oe), .read_write_n(read_write_n), .read_write_oe(read_write_oe),
    .region_select_n(region_select_n), .output_enable_n(output_enable_n),
    .data_oe(data_oe));
`default_nettype wire
